// [hw/ism_pkg.sv]
// Types for the interrupt source map
package ism_pkg;
    // Per-wake-source mode setting
    typedef struct packed {
        logic       wake_source_enable;
        logic [1:0] wake_active_level_sel;
    } ism_wake_mode_s;
endpackage

// [hw/ism_regs.svh]
// Constants for the interrupt source map and wake-up detection
`ifndef ISM_REGS_SVH
`define ISM_REGS_SVH

// Source numbers
`define ISM_SRC_SERIAL0_RX   0
`define ISM_SRC_SERIAL0_TX   1
`define ISM_SRC_SERIAL1_RX   2
`define ISM_SRC_SERIAL1_TX   3
`define ISM_SRC_TIMER0_CMP0  8
`define ISM_SRC_TIMER0_CMP1  9
`define ISM_SRC_EXT_PIN_A    19
`define ISM_SRC_EXT_PIN_B    20
`define ISM_SRC_CONV_B_SW    23
`define ISM_SRC_CONV_B_TMR   24
`define ISM_SRC_ENCODER0     25
`define ISM_SRC_EXT_PIN_C    30
`define ISM_SRC_SERIAL_BUS   31

// Counts
`define ISM_NUM_SRC          32
`define ISM_NUM_WAKE         3

// Active level codes in wake_active_level_sel
`define ISM_LVL_LOW          2'h0
`define ISM_LVL_HIGH         2'h1
`define ISM_LVL_FALL         2'h2
`define ISM_LVL_RISE         2'h3

// Wake slice index of each pin
`define ISM_WAKE_IDX_A       0
`define ISM_WAKE_IDX_B       1
`define ISM_WAKE_IDX_C       2

// Slot mask seed and sync fill depth
`define ISM_SLOT_ONE         32'h0000_0001
`define ISM_ARM_STAGES       3

// Reset values
`define ISM_WAKE_EN_RST      3'h0
`define ISM_PIN_RST          3'h0
`define ISM_ARM_RST          3'h0
`define ISM_IRQ_RST          32'h0000_0000

`endif

// [hw/ism_top.sv]
// Interrupt source aggregation with wake-source edge/level detection
//
// Function
// [RL1] CPU takes high line as request
// [RL2] Direct peripheral lines drive high when pending
// [RL3] Wake peripheral requests detected on edges
// [RL4] Pins selectable level or edge, either polarity
// [RL5] Software sets enable and active level
// [RL6] Detected request goes to CPU high
// [RL7] Serial 0/1 rx, tx at 0..3
// [RL8] Timer0 compare0/overflow 8, compare1 9
// [RL9] Pins 19, 20, 30 are wake sources
// [RL10] Converter B software 23, timer 24
// [RL11] Encoder0 at 25, serial bus 31
// [RL12] Detected request held until cleared
// [RL13] Edges latched, levels follow input
// [RL14] Other lines forwarded by source number
`timescale 1ns/1ps
`include "ism_regs.svh"

module ism_top
    import ism_pkg::*;
(
    input  wire logic                    ref_clk_in,
    input  wire logic                    rst_in,
    input  wire logic [`ISM_NUM_SRC-1:0] periph_irq_in,
    input  wire logic                    ext_pin_a_irq_in,
    input  wire logic                    ext_pin_b_irq_in,
    input  wire logic                    ext_pin_c_irq_in,
    input  wire ism_wake_mode_s          wake_source_mode_in
                                         [`ISM_NUM_WAKE],
    input  wire logic [`ISM_NUM_WAKE-1:0] wake_request_clear_in,
    output logic [`ISM_NUM_SRC-1:0]      cpu_irq_out
);

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers: pins are asynchronous to the system clock
    logic [`ISM_NUM_WAKE-1:0] pin_meta_reg;
    logic [`ISM_NUM_WAKE-1:0] pin_sync_reg;
    logic [`ISM_NUM_WAKE-1:0] pin_prev_reg;
    wire  [`ISM_NUM_WAKE-1:0] pin_raw;

    assign pin_raw = {ext_pin_c_irq_in, ext_pin_b_irq_in,
                      ext_pin_a_irq_in};

    // Two stages against metastability; only the second is read
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            pin_meta_reg <= `ISM_PIN_RST;
            pin_sync_reg <= `ISM_PIN_RST;
        end else begin
            pin_meta_reg <= pin_raw;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // One more stage of history for edge detection
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            pin_prev_reg <= `ISM_PIN_RST;
        end else begin
            pin_prev_reg <= pin_sync_reg;
        end
    end

    // Fill marker: a pin already high at release is not taken for a
    // rise, since the history still holds reset values for a while
    logic [`ISM_ARM_STAGES-1:0] arm_reg;
    wire                        sync_armed;

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            arm_reg <= `ISM_ARM_RST;
        end else begin
            arm_reg <= {arm_reg[`ISM_ARM_STAGES-2:0], 1'h1};
        end
    end

    assign sync_armed = arm_reg[`ISM_ARM_STAGES-1];

    ////////////////////////////////////////////////////////////////////
    // Wake-source detection, one slice per pin
    logic [`ISM_NUM_WAKE-1:0] held_reg;
    logic [`ISM_NUM_WAKE-1:0] held_next;
    wire  [`ISM_NUM_WAKE-1:0] wake_req;

    genvar g;
    generate
        for (g = 0; g < `ISM_NUM_WAKE; g++) begin : g_wake
            // Mode fields and pin views
            wire       en;
            wire [1:0] lvl;
            wire       clr;
            wire       pin_now;
            wire       pin_before;
            // Level code decodes
            wire       want_low;
            wire       want_high;
            wire       want_fall;
            wire       want_rise;
            wire       is_edge;
            // Detection terms
            wire       rise;
            wire       fall;
            wire       edge_hit;
            wire       lvl_hit;
            wire       set_hit;
            wire       keep_hit;

            // Mode fields and clear of this source
            assign en  = wake_source_mode_in[g].wake_source_enable;
            assign lvl = wake_source_mode_in[g].wake_active_level_sel;
            assign clr = wake_request_clear_in[g];

            // Second sync stage and its history only
            assign pin_now    = pin_sync_reg[g];
            assign pin_before = pin_prev_reg[g];

            // One decode per active level code
            assign want_low  = (lvl == `ISM_LVL_LOW);
            assign want_high = (lvl == `ISM_LVL_HIGH);
            assign want_fall = (lvl == `ISM_LVL_FALL);
            assign want_rise = (lvl == `ISM_LVL_RISE);
            assign is_edge   = want_rise | want_fall;

            // Edges only count once the history is filled
            assign rise = sync_armed & pin_now & ~pin_before;
            assign fall = sync_armed & ~pin_now & pin_before;

            // Detection by the configured active level
            assign edge_hit = (want_rise & rise) | (want_fall & fall); // RL3
            assign lvl_hit  = (want_high & pin_now) |
                              (want_low & ~pin_now); // RL4

            // Set wins over clear so a coincident edge is not lost
            assign set_hit      = en & edge_hit;
            assign keep_hit     = held_reg[g] & ~clr;
            assign held_next[g] = set_hit | keep_hit; // RL12 RL13

            // Level request exists only while the level stands
            assign wake_req[g] = en & (is_edge ? held_next[g]
                                               : lvl_hit); // RL13 RL6
        end
    endgenerate

    // Edge latches
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            held_reg <= `ISM_WAKE_EN_RST;
        end else begin
            held_reg <= held_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Named direct sources, each active high from its peripheral
    // Serial channels
    wire serial0_rx_irq;
    wire serial0_tx_irq;
    wire serial1_rx_irq;
    wire serial1_tx_irq;

    // First timer channel
    wire timer0_cmp0_ovf_irq;
    wire timer0_cmp1_irq;

    // Second converter unit
    wire conv_b_sw_done_irq;
    wire conv_b_timer_done_irq;

    // Encoder and serial bus
    wire encoder0_irq;
    wire serial_bus_irq;

    // Serial channels
    assign serial0_rx_irq = periph_irq_in[`ISM_SRC_SERIAL0_RX]; // RL2
    assign serial0_tx_irq = periph_irq_in[`ISM_SRC_SERIAL0_TX]; // RL2
    assign serial1_rx_irq = periph_irq_in[`ISM_SRC_SERIAL1_RX]; // RL2
    assign serial1_tx_irq = periph_irq_in[`ISM_SRC_SERIAL1_TX]; // RL2

    // First timer channel
    assign timer0_cmp0_ovf_irq = periph_irq_in[`ISM_SRC_TIMER0_CMP0];
    assign timer0_cmp1_irq     = periph_irq_in[`ISM_SRC_TIMER0_CMP1];

    // Second converter unit
    assign conv_b_sw_done_irq    = periph_irq_in[`ISM_SRC_CONV_B_SW];
    assign conv_b_timer_done_irq = periph_irq_in[`ISM_SRC_CONV_B_TMR];

    // Encoder and serial bus
    assign encoder0_irq   = periph_irq_in[`ISM_SRC_ENCODER0];
    assign serial_bus_irq = periph_irq_in[`ISM_SRC_SERIAL_BUS];

    // Named wake sources; their direct lines are ignored on purpose
    wire ext_pin_a_irq;
    wire ext_pin_b_irq;
    wire ext_pin_c_irq;

    assign ext_pin_a_irq = wake_req[`ISM_WAKE_IDX_A];
    assign ext_pin_b_irq = wake_req[`ISM_WAKE_IDX_B];
    assign ext_pin_c_irq = wake_req[`ISM_WAKE_IDX_C];

    ////////////////////////////////////////////////////////////////////
    // Slots held by a named source; the pass-through may not claim them
    localparam logic [`ISM_NUM_SRC-1:0] named_slot_mask =
        // Serial channels
        (`ISM_SLOT_ONE << `ISM_SRC_SERIAL0_RX)  |
        (`ISM_SLOT_ONE << `ISM_SRC_SERIAL0_TX)  |
        (`ISM_SLOT_ONE << `ISM_SRC_SERIAL1_RX)  |
        (`ISM_SLOT_ONE << `ISM_SRC_SERIAL1_TX)  |
        // First timer channel
        (`ISM_SLOT_ONE << `ISM_SRC_TIMER0_CMP0) |
        (`ISM_SLOT_ONE << `ISM_SRC_TIMER0_CMP1) |
        // Wake pins
        (`ISM_SLOT_ONE << `ISM_SRC_EXT_PIN_A)   |
        (`ISM_SLOT_ONE << `ISM_SRC_EXT_PIN_B)   |
        (`ISM_SLOT_ONE << `ISM_SRC_EXT_PIN_C)   |
        // Converter, encoder and serial bus
        (`ISM_SLOT_ONE << `ISM_SRC_CONV_B_SW)   |
        (`ISM_SLOT_ONE << `ISM_SRC_CONV_B_TMR)  |
        (`ISM_SLOT_ONE << `ISM_SRC_ENCODER0)    |
        (`ISM_SLOT_ONE << `ISM_SRC_SERIAL_BUS);

    // Source map: wake pins replace their slots, others pass through
    wire [`ISM_NUM_SRC-1:0] irq_next;

    // Unnamed slots pass straight through by source number
    genvar s;
    generate
        for (s = 0; s < `ISM_NUM_SRC; s++) begin : g_slot
            if (!named_slot_mask[s]) begin : g_pass
                assign irq_next[s] = periph_irq_in[s]; // RL14 RL2
            end
        end
    endgenerate

    // Serial channels
    assign irq_next[`ISM_SRC_SERIAL0_RX]  = serial0_rx_irq;        // RL7
    assign irq_next[`ISM_SRC_SERIAL0_TX]  = serial0_tx_irq;        // RL7
    assign irq_next[`ISM_SRC_SERIAL1_RX]  = serial1_rx_irq;        // RL7
    assign irq_next[`ISM_SRC_SERIAL1_TX]  = serial1_tx_irq;        // RL7

    // First timer channel
    assign irq_next[`ISM_SRC_TIMER0_CMP0] = timer0_cmp0_ovf_irq;   // RL8
    assign irq_next[`ISM_SRC_TIMER0_CMP1] = timer0_cmp1_irq;       // RL8

    // Wake pins, each from its detector slice
    assign irq_next[`ISM_SRC_EXT_PIN_A]   = ext_pin_a_irq;         // RL9
    assign irq_next[`ISM_SRC_EXT_PIN_B]   = ext_pin_b_irq;         // RL9
    assign irq_next[`ISM_SRC_EXT_PIN_C]   = ext_pin_c_irq;         // RL9

    // Converter, encoder and serial bus
    assign irq_next[`ISM_SRC_CONV_B_SW]   = conv_b_sw_done_irq;    // RL10
    assign irq_next[`ISM_SRC_CONV_B_TMR]  = conv_b_timer_done_irq; // RL10
    assign irq_next[`ISM_SRC_ENCODER0]    = encoder0_irq;          // RL11
    assign irq_next[`ISM_SRC_SERIAL_BUS]  = serial_bus_irq;        // RL11

    // Registered so every output comes from a flip-flop; costs one
    // cycle of latency to the CPU
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            cpu_irq_out <= `ISM_IRQ_RST;
        end else begin
            cpu_irq_out <= irq_next; // RL1 RL7 RL8 RL10
        end
    end

endmodule

// [test/ism_assertions.sv]
// Checker for the source map and wake detection
`timescale 1ns/1ps
`include "ism_regs.svh"
module ism_chk
    import ism_pkg::*;
(
    input wire logic                     ref_clk_in,
    input wire logic                     rst_in,
    input wire logic [`ISM_NUM_SRC-1:0]  periph_irq_in,
    input wire logic                     ext_pin_a_irq_in,
    input wire logic                     ext_pin_b_irq_in,
    input wire logic                     ext_pin_c_irq_in,
    input wire ism_wake_mode_s           wake_source_mode_in
                                         [`ISM_NUM_WAKE],
    input wire logic [`ISM_NUM_WAKE-1:0] wake_request_clear_in,
    input wire logic [`ISM_NUM_SRC-1:0]  cpu_irq_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    // Mode decodes: a rising, b falling, c high level
    wire ra = wake_source_mode_in[0] == 3'h7;
    wire fb = wake_source_mode_in[1] == 3'h6;
    wire hc = wake_source_mode_in[2] == 3'h5;
    sequence rise_a; ($rose(ext_pin_a_irq_in) && ra) ##1 ra[*3]; endsequence
    sequence fall_b; ($fell(ext_pin_b_irq_in) && fb) ##1 fb[*3]; endsequence
    dir_map_a: assert property ((cpu_irq_out & 32'hBFE7_FFFF) ==
        ($past(periph_irq_in) & 32'hBFE7_FFFF)) else $error("direct line");
    rise_det_a: assert property (rise_a |-> cpu_irq_out[19])
        else $error("rise missed");
    fall_det_a: assert property (fall_b |-> cpu_irq_out[20])
        else $error("fall missed");
    edge_hold_a: assert property ((cpu_irq_out[19] && ra &&
        !wake_request_clear_in[0] && !$past(wake_request_clear_in[0])) ##1 ra
        |-> cpu_irq_out[19]) else $error("latch lost");
    clr_drop_a: assert property ((wake_request_clear_in[0] && ra &&
        !ext_pin_a_irq_in)[*6] |-> !cpu_irq_out[19]) else $error("no clear");
    lvl_high_a: assert property ((hc && ext_pin_c_irq_in)[*4]
        |-> cpu_irq_out[30]) else $error("level high missed");
    lvl_low_a: assert property ((hc && !ext_pin_c_irq_in)[*4]
        |-> !cpu_irq_out[30]) else $error("level not followed");
    dis_zero_a: assert property
        ((!wake_source_mode_in[0].wake_source_enable)[*2] |-> !cpu_irq_out[19])
        else $error("disabled source active");
    rst_zero_a: assert property (disable iff (1'b0) rst_in
        |=> cpu_irq_out == 32'h0000_0000) else $error("reset not clear");
endmodule
bind ism_top ism_chk chk (.*);

// [test/ism_cpu_model.sv]
// CPU interrupt controller model: pending bits
`timescale 1ns/1ps
module ism_cpu_model (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic [31:0] irq_in,
    input  wire logic [31:0] ack_in,
    output logic      [31:0] pend_out
);
    // A high line pends until acknowledged
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pend_out <= 32'h0000_0000;
        end else begin
            pend_out <= (pend_out & ~ack_in) | irq_in;
        end
    end
endmodule

// [test/tb_top.sv]
// Self-checking bench for the interrupt source map
`timescale 1ns/1ps
module tb_top;
    import ism_pkg::*;
    logic           clk = 0, rst = 1, pa = 0, pb = 0, pc = 0;
    logic [31:0]    per = 0, ack = 0, irq, pend;
    logic [2:0]     clr = 0;
    ism_wake_mode_s md [3] = '{default: '0};
    int             n_mismatch = 0, cmp_count = 0, cyc = 0;
    ism_top dut (.ref_clk_in(clk), .rst_in(rst), .periph_irq_in(per),
        .ext_pin_a_irq_in(pa), .ext_pin_b_irq_in(pb), .ext_pin_c_irq_in(pc),
        .wake_source_mode_in(md), .wake_request_clear_in(clr),
        .cpu_irq_out(irq));
    ism_cpu_model cpu (.clk_in(clk), .rst_in(rst), .irq_in(irq),
        .ack_in(ack), .pend_out(pend));
    initial forever #5 clk = ~clk;
    // Hang guard: the run needs well under 300 cycles
    always @(posedge clk) if (++cyc > 2000) begin
        n_mismatch++;
        test_done();
    end
    task step(int n); repeat (n) @(posedge clk); #1; endtask
    task chk(string nm, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    task test_done;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task t_direct;
        int s [10] = '{0, 1, 2, 3, 8, 9, 23, 24, 25, 31};
        foreach (s[i]) begin
            per = 32'h1 << s[i];
            step(1);
            chk("direct", 32'h1 << s[i], irq);
        end
        per = 32'h4018_0000;
        step(2);
        chk("wake bits", 0, irq);
        chk("pending", 32'h8380_030F, pend);
        ack = 32'hFFFF_FFFF;
        step(1);
        ack = 0;
        chk("acked", 0, pend);
        per = 0;
        $display("direct done");
    endtask
    task t_edge;
        md[0] = 3'h7;
        md[1] = 3'h6;
        pb = 1;
        step(4);
        chk("no rise in fall mode", 0, irq);
        pa = 1;
        pb = 0;
        step(4);
        pa = 0;
        step(4);
        chk("latched", 32'h0018_0000, irq);
        clr = 3'h3;
        step(6);
        clr = 0;
        chk("cleared", 0, irq);
        md[0] = 3'h3;
        pa = 1;
        step(4);
        pa = 0;
        md[0] = 3'h7;
        step(4);
        chk("disabled", 0, irq);
        $display("edge done");
    endtask
    task t_level;
        md[2] = 3'h5;
        pc = 1;
        step(4);
        chk("level high", 32'h4000_0000, irq);
        pc = 0;
        step(4);
        chk("level gone", 0, irq);
        md[2] = 3'h4;
        step(4);
        chk("level low", 32'h4000_0000, irq);
        $display("level done");
    endtask
    task t_reset;
        md[2] = 3'h0;
        pa = 1;
        step(4);
        chk("pre reset", 32'h0008_0000, irq);
        rst = 1;
        step(2);
        rst = 0;
        step(1);
        chk("reset clear", 0, irq);
        step(6);
        chk("no false edge", 0, irq);
        pa = 0;
        $display("reset done");
    endtask
    initial begin
        repeat (12) @(posedge clk);
        #1 rst = 0;
        step(1);
        t_direct();
        t_edge();
        t_level();
        t_reset();
        test_done();
    end
endmodule
